// >>> hdl/swr_defines.svh
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

// ==========================================
// Register indices, byte address is four times the index
`define SWR_IDX_CTL 6'h0b
`define SWR_IDX_CTL2 6'h0d
`define SWR_IDX_PDIR 6'h0e
`define SWR_IDX_STAT 6'h0f

// ==========================================
// Field positions
`define SWR_WARM_BIT 7
`define SWR_LEVEL_BIT 6
`define SWR_DLY_BIT 5
`define SWR_SRC_HI 4
`define SWR_SRC_LO 2
`define SWR_STOP_BIT 0
`define SWR_BUSY_BIT 1
`define SWR_PDIR_P2_HI 7
`define SWR_PDIR_P3_HI 10
`define SWR_PDIR_P3_LO 8
`define SWR_PDIR_P0B0 11
`define SWR_PDIR_P0B7 12

// ==========================================
// Reset values
`define SWR_SRC_RST 3'h0
`define SWR_LEVEL_RST 1'b0
`define SWR_DLY_RST 1'b1
`define SWR_PDIR_RST 13'h0000

// ==========================================
// Source codes
`define SWR_SRC_NONE 3'h0
`define SWR_SRC_1 3'h1
`define SWR_SRC_2 3'h2
`define SWR_SRC_3 3'h3
`define SWR_SRC_4 3'h4
`define SWR_SRC_5 3'h5
`define SWR_SRC_6 3'h6
`define SWR_SRC_7 3'h7

// ==========================================
// Wake-up delay timing
`define SWR_CLK_MHZ 250
`define SWR_TPOR_NS 1000
`define SWR_TPOR_CYC ((`SWR_TPOR_NS * `SWR_CLK_MHZ + 999) / 1000)
`define SWR_CNT_W 16

`endif

// >>> hdl/swr_pkg.sv
package swr_pkg;

   typedef enum logic [1:0] {
      SWR_RUN = 2'b00,
      SWR_STOP = 2'b01,
      SWR_WAKE_DLY = 2'b10
   } swr_state_t;

endpackage

// >>> hdl/swr_sync.sv
`timescale 1ns/1ns

// ==========================================
// Two-flop synchroniser, one chain per bit
module swr_sync #(
   parameter int W = 14
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate

endmodule

// >>> hdl/swr_delay.sv
`timescale 1ns/1ns
`include "swr_defines.svh"

// ==========================================
// Wake-up delay counter
module swr_delay #(
   parameter logic [`SWR_CNT_W-1:0] DLY_CYC = `SWR_CNT_W'(`SWR_TPOR_CYC)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   output logic busy
);

   logic [`SWR_CNT_W-1:0] count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (start) begin
         count <= DLY_CYC;
      end else if (count != '0) begin
         count <= count - `SWR_CNT_W'(1);
      end
   end

   assign busy = (count != '0);

endmodule

// >>> hdl/swr_top.sv
`timescale 1ns/1ns
`include "swr_defines.svh"

// How it works
// - Second register codes 0-4 pick wake logic
// - Codes 5-7 add port0 or port2 pins
// - Second register bit 6 sets level
// - Output pins excluded from second register logic
// - Main register bits 4..2 pick wake source
// - Port2 output bits read as inactive
// - Bit 5 enables wake delay, default one
// - Bit 6 sets wake level, default low
// - Bit 7 reads one after stop wake
module swr_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port2_pin,
   input wire logic [3:1] port3_pin,
   input wire logic port0_bit0,
   input wire logic port0_bit7,
   input wire logic ext_reset_n,
   output logic sys_clk_en,
   output logic cpu_run,
   output logic warm_start
);

   // ==========================================
   // Pin synchronisers
   logic [7:0] p2;
   logic [3:1] p3;
   logic p0b0;
   logic p0b7;
   logic ext_reset_n_s;

   swr_sync #(.W(14)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({ext_reset_n, port0_bit7, port0_bit0, port3_pin, port2_pin}),
      .q({ext_reset_n_s, p0b7, p0b0, p3, p2})
   );

   logic ext_rst;
   assign ext_rst = !ext_reset_n_s;

   // ==========================================
   // APB decode
   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   logic sel_ctl;
   logic sel_ctl2;
   logic sel_pdir;
   logic sel_stat;
   logic mapped;
   logic wr_en;
   logic setup;

   assign sel_ctl = hit(paddr, `SWR_IDX_CTL);
   assign sel_ctl2 = hit(paddr, `SWR_IDX_CTL2);
   assign sel_pdir = hit(paddr, `SWR_IDX_PDIR);
   assign sel_stat = hit(paddr, `SWR_IDX_STAT);
   assign mapped = sel_ctl | sel_ctl2 | sel_pdir | sel_stat;
   assign wr_en = psel & penable & pwrite & mapped;
   assign setup = psel & !penable;
   assign pready = 1'b1;
   assign pslverr = psel & penable & !mapped;

   // ==========================================
   // Registers
   logic [2:0] src;
   logic level;
   logic dly_en;
   logic [2:0] src2;
   logic level2;
   logic [12:0] pdir;
   logic warm;
   swr_pkg::swr_state_t state;
   logic dly_busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src <= `SWR_SRC_RST;
         level <= `SWR_LEVEL_RST;
         dly_en <= `SWR_DLY_RST;
      end else if (wr_en && sel_ctl) begin
         src <= pwdata[`SWR_SRC_HI:`SWR_SRC_LO];
         level <= pwdata[`SWR_LEVEL_BIT];
         dly_en <= pwdata[`SWR_DLY_BIT];
      end
   end

   // Reserved bits are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src2 <= `SWR_SRC_RST;
         level2 <= `SWR_LEVEL_RST;
      end else if (wr_en && sel_ctl2) begin
         src2 <= pwdata[`SWR_SRC_HI:`SWR_SRC_LO];
         level2 <= pwdata[`SWR_LEVEL_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdir <= `SWR_PDIR_RST;
      end else if (wr_en && sel_pdir) begin
         pdir <= pwdata[`SWR_PDIR_P0B7:0];
      end
   end

   // ==========================================
   // Read data, captured in the setup cycle
   logic [31:0] next_prdata;

   always_comb begin
      next_prdata = '0;
      if (sel_ctl) begin
         next_prdata[`SWR_WARM_BIT] = warm;
         next_prdata[`SWR_LEVEL_BIT] = level;
         next_prdata[`SWR_DLY_BIT] = dly_en;
         next_prdata[`SWR_SRC_HI:`SWR_SRC_LO] = src;
      end else if (sel_pdir) begin
         next_prdata[`SWR_PDIR_P0B7:0] = pdir;
      end else if (sel_stat) begin
         next_prdata[`SWR_STOP_BIT] = (state == swr_pkg::SWR_STOP);
         next_prdata[`SWR_BUSY_BIT] = (state == swr_pkg::SWR_WAKE_DLY);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup) begin
         prdata <= next_prdata;
      end
   end

   // ==========================================
   // Wake source logic
   logic [7:0] m2;
   logic [3:1] m3;
   logic [1:0] m0;

   assign m2 = pdir[`SWR_PDIR_P2_HI:0];
   assign m3 = pdir[`SWR_PDIR_P3_HI:`SWR_PDIR_P3_LO];
   assign m0 = {pdir[`SWR_PDIR_P0B7], pdir[`SWR_PDIR_P0B0]};

   // Masked inputs present the inactive value for the gate
   function automatic logic comb(input logic is_nand, input logic [7:0] b,
                                 input logic [7:0] m);
      if (is_nand) begin
         comb = ~&(b | m);
      end else begin
         comb = ~|(b & ~m);
      end
   endfunction

   logic two_out;
   logic two_hit;

   always_comb begin
      two_out = 1'b0;
      unique case (src2)
         `SWR_SRC_NONE: two_out = 1'b0;
         `SWR_SRC_1: two_out = comb(1'b1, {4'hf, p2[3:0]}, {4'hf, m2[3:0]});
         `SWR_SRC_2: two_out = comb(1'b1, p2, m2);
         `SWR_SRC_3: two_out = comb(1'b0, {5'h1f, p3}, {5'h1f, m3});
         `SWR_SRC_4: two_out = comb(1'b1, {5'h1f, p3}, {5'h1f, m3});
         `SWR_SRC_5: two_out = comb(1'b0, {3'h7, p0b7, p0b0, p3},
                                    {3'h7, m0, m3});
         `SWR_SRC_6: two_out = comb(1'b1, {3'h7, p0b7, p0b0, p3},
                                    {3'h7, m0, m3});
         `SWR_SRC_7: two_out = comb(1'b1, {2'h3, p2[2:0], p3},
                                    {2'h3, m2[2:0], m3});
      endcase
   end

   assign two_hit = (src2 != `SWR_SRC_NONE) && (two_out == level2);

   logic main_out;
   logic main_ok;
   logic main_hit;

   always_comb begin
      main_out = 1'b0;
      main_ok = 1'b1;
      unique case (src)
         `SWR_SRC_NONE: main_ok = 1'b0;
         `SWR_SRC_1: main_ok = 1'b0;
         `SWR_SRC_2: begin
            main_out = p3[1];
            main_ok = !m3[1];
         end
         `SWR_SRC_3: begin
            main_out = p3[2];
            main_ok = !m3[2];
         end
         `SWR_SRC_4: begin
            main_out = p3[3];
            main_ok = !m3[3];
         end
         `SWR_SRC_5: begin
            main_out = p2[7];
            main_ok = !m2[7];
         end
         `SWR_SRC_6: main_out = comb(1'b0, {4'h0, p2[3:0]}, {4'hf, m2[3:0]});
         `SWR_SRC_7: main_out = comb(1'b0, p2, m2);
      endcase
   end

   assign main_hit = main_ok && (main_out == level);

   logic wake;
   assign wake = main_hit | two_hit;

   // ==========================================
   // Stop sequencer
   logic stop_req;
   logic dly_start;
   swr_pkg::swr_state_t next_state;

   assign stop_req = wr_en && sel_stat && pwdata[`SWR_STOP_BIT];
   assign dly_start = (state == swr_pkg::SWR_STOP) && wake && dly_en && !ext_rst;

   always_comb begin
      next_state = state;
      unique case (state)
         swr_pkg::SWR_RUN: next_state = stop_req ? swr_pkg::SWR_STOP : swr_pkg::SWR_RUN;
         swr_pkg::SWR_STOP: begin
            if (wake) begin
               next_state = dly_en ? swr_pkg::SWR_WAKE_DLY : swr_pkg::SWR_RUN;
            end
         end
         swr_pkg::SWR_WAKE_DLY: next_state = dly_busy ? swr_pkg::SWR_WAKE_DLY : swr_pkg::SWR_RUN;
         default: next_state = swr_pkg::SWR_RUN;
      endcase
      if (ext_rst) begin
         next_state = swr_pkg::SWR_RUN;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= swr_pkg::SWR_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Cold/warm start flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm <= 1'b0;
      end else if (ext_rst) begin
         warm <= 1'b0;
      end else if (state == swr_pkg::SWR_STOP && wake) begin
         warm <= 1'b1;
      end
   end

   swr_delay u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .start(dly_start),
      .busy(dly_busy)
   );

   assign sys_clk_en = (state != swr_pkg::SWR_STOP);
   assign cpu_run = (state == swr_pkg::SWR_RUN);
   assign warm_start = warm;

   // ==========================================
   // Checks
   property p_clk_halt;
      @(posedge pclk) disable iff (!presetn)
      (state == swr_pkg::SWR_STOP) && !wake && !ext_rst |=> !sys_clk_en;
   endproperty
   a_clk_halt: assert property (p_clk_halt) else $error("clock runs in stop");
   property p_fast_wake;
      @(posedge pclk) disable iff (!presetn)
      (state == swr_pkg::SWR_STOP) && wake && !dly_en && !ext_rst |=> cpu_run && warm;
   endproperty
   a_fast_wake: assert property (p_fast_wake) else $error("fast wake failed");
   property p_slow_wake;
      @(posedge pclk) disable iff (!presetn)
      (state == swr_pkg::SWR_STOP) && wake && dly_en && !ext_rst
         |=> (!cpu_run && sys_clk_en) [*3];
   endproperty
   a_slow_wake: assert property (p_slow_wake) else $error("delay skipped");
   property p_warm_clear;
      @(posedge pclk) disable iff (!presetn)
      ext_rst |=> !warm_start && cpu_run;
   endproperty
   a_warm_clear: assert property (p_warm_clear) else $error("warm flag kept");
   property p_ctl2_wo;
      @(posedge pclk) disable iff (!presetn)
      setup && sel_ctl2 |=> prdata == 32'h0000_0000;
   endproperty
   a_ctl2_wo: assert property (p_ctl2_wo) else $error("write-only reg read");
   property p_two_none;
      @(posedge pclk) disable iff (!presetn)
      src2 == `SWR_SRC_NONE |-> !two_hit;
   endproperty
   a_two_none: assert property (p_two_none) else $error("code 000 wakes");
   property p_main_rsvd;
      @(posedge pclk) disable iff (!presetn)
      (src == `SWR_SRC_NONE || src == `SWR_SRC_1) |-> !main_hit;
   endproperty
   a_main_rsvd: assert property (p_main_rsvd) else $error("reserved code wakes");
   property p_out_ignored;
      @(posedge pclk) disable iff (!presetn)
      src == `SWR_SRC_6 && m2[0] && p2[0] && p2[3:1] == 3'h0 |-> main_out;
   endproperty
   a_out_ignored: assert property (p_out_ignored) else $error("output pin wakes");
   property p_level_wr;
      @(posedge pclk) disable iff (!presetn)
      wr_en && sel_ctl ##1 !psel ##1 setup && sel_ctl
         |=> prdata[`SWR_LEVEL_BIT] == $past(pwdata[`SWR_LEVEL_BIT], 3);
   endproperty
   a_level_wr: assert property (p_level_wr) else $error("level not stored");

endmodule

// >>> verif/swr_pin_model.sv
`timescale 1ns/1ns

// ==========================================
// Port pins driven by the circuit around the device
module swr_pin_model (
   input wire logic pclk,
   input wire logic req,
   input wire logic [12:0] pat,
   output logic holding,
   output logic [7:0] port2_pin,
   output logic [3:1] port3_pin,
   output logic port0_bit0,
   output logic port0_bit7
);
   logic [2:0] cnt = 3'h0;
   logic [12:0] pins = 13'h0000;
   assign holding = cnt != 3'h0;
   assign {port0_bit7, port0_bit0, port3_pin, port2_pin} = pins;

   // ==========================================
   // A new level is taken only after the last one stood six clocks
   always_ff @(posedge pclk) begin
      if (req && !holding) begin
         pins <= pat;
         cnt <= 3'h5;
      end else if (holding) begin
         cnt <= cnt - 3'h1;
      end
   end
endmodule

// >>> verif/swr_top_tb_top.sv
`timescale 1ns/1ns
`include "swr_defines.svh"

module swr_top_tb_top;
   localparam logic [7:0] A_CTL = {`SWR_IDX_CTL, 2'b00};
   localparam logic [7:0] A_CTL2 = {`SWR_IDX_CTL2, 2'b00};
   localparam logic [7:0] A_PDIR = {`SWR_IDX_PDIR, 2'b00};
   localparam logic [7:0] A_STAT = {`SWR_IDX_STAT, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ext_reset_n = 1'b1;
   logic req = 1'b0;
   logic [12:0] pat = 13'h0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, holding, sys_clk_en, cpu_run, warm_start;
   logic port0_bit0, port0_bit7;
   logic [7:0] port2_pin;
   logic [3:1] port3_pin;
   int errors = 0;
   int check_count = 0;

   always #2 pclk = ~pclk;

   swr_top u_swr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port2_pin(port2_pin), .port3_pin(port3_pin),
      .port0_bit0(port0_bit0), .port0_bit7(port0_bit7), .ext_reset_n(ext_reset_n),
      .sys_clk_en(sys_clk_en), .cpu_run(cpu_run), .warm_start(warm_start));

   swr_pin_model u_swr_pin_model (.pclk(pclk), .req(req), .pat(pat), .holding(holding),
      .port2_pin(port2_pin), .port3_pin(port3_pin), .port0_bit0(port0_bit0),
      .port0_bit7(port0_bit7));

   // ==========================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t: %s", $time, msg);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_pins(input logic [12:0] p);
      @(posedge pclk);
      req <= 1'b1;
      pat <= p;
      @(posedge pclk);
      req <= 1'b0;
      @(posedge pclk);
      while (holding === 1'b1) @(posedge pclk);
   endtask

   task automatic wait_run(input int lim);
      for (int i = 0; i < lim && cpu_run !== 1'b1; i++) @(posedge pclk);
   endtask

   task automatic report_and_stop;
      if (errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic test_reset;
      apb(1'b0, A_CTL, 32'h0);
      check(rd, 32'h20, "main reset value");
      apb(1'b0, A_CTL2, 32'h0);
      check(rd, 32'h0, "second reg readable");
      apb(1'b0, 8'h00, 32'h0);
      check(32'(err), 32'h1, "unmapped not refused");
      apb(1'b1, A_CTL, 32'hfc);
      apb(1'b0, A_CTL, 32'h0);
      check(rd, 32'h7c, "warm bit writable");
   endtask

   task automatic run_case(input logic sel, input logic [2:0] c, input logic lv,
      input logic [12:0] pd, input logic [12:0] mi, input logic [12:0] wk);
      logic [31:0] v;
      v = {24'h0, 1'b0, lv, 1'b0, c, 2'b00};
      apb(1'b1, A_CTL, sel ? 32'h0 : v);
      apb(1'b1, A_CTL2, sel ? v : 32'h0);
      apb(1'b1, A_PDIR, {19'h0, pd});
      set_pins(mi);
      apb(1'b1, A_STAT, 32'h1);
      repeat (8) @(posedge pclk);
      check(32'(sys_clk_en), 32'h0, "left stop");
      apb(1'b0, A_STAT, 32'h0);
      check(rd, 32'h1, "stop not flagged");
      set_pins(wk);
      wait_run(20);
      check(32'(cpu_run), 32'h1, "no fast wake");
      apb(1'b0, A_CTL, 32'h0);
      check(32'(rd[7]), 32'h1, "warm flag clear");
      apb(1'b1, A_PDIR, 32'h0);
      set_pins(13'h0000);
   endtask

   task automatic test_delay;
      apb(1'b1, A_CTL, 32'h68);
      apb(1'b1, A_CTL2, 32'h0);
      apb(1'b1, A_STAT, 32'h1);
      set_pins(13'h0100);
      repeat (200) @(posedge pclk);
      check(32'({sys_clk_en, cpu_run}), 32'h2, "delay cut short");
      apb(1'b0, A_STAT, 32'h0);
      check(rd, 32'h2, "delay not flagged");
      wait_run(100);
      check(32'(cpu_run), 32'h1, "delay never ended");
      set_pins(13'h0000);
   endtask

   task automatic test_no_wake;
      for (int c = 0; c < 2; c++) begin
         apb(1'b1, A_CTL, {27'h0, 3'(c), 2'b00});
         set_pins(13'h1fff);
         apb(1'b1, A_STAT, 32'h1);
         set_pins(13'h0000);
         repeat (10) @(posedge pclk);
         check(32'(sys_clk_en), 32'h0, "woke on reset-only source");
         @(posedge pclk);
         ext_reset_n <= 1'b0;
         repeat (4) @(posedge pclk);
         ext_reset_n <= 1'b1;
         wait_run(20);
         check(32'({cpu_run, warm_start}), 32'h2, "reset exit");
      end
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      run_case(1'b0, 3'h2, 1'b1, 13'h0, 13'h0600, 13'h0100);
      run_case(1'b0, 3'h3, 1'b1, 13'h0, 13'h0500, 13'h0200);
      run_case(1'b0, 3'h4, 1'b1, 13'h0, 13'h0380, 13'h0400);
      run_case(1'b0, 3'h5, 1'b1, 13'h0, 13'h0700, 13'h0080);
      run_case(1'b0, 3'h6, 1'b0, 13'h0, 13'h00f0, 13'h0008);
      run_case(1'b0, 3'h7, 1'b0, 13'h0, 13'h0700, 13'h0080);
      run_case(1'b0, 3'h6, 1'b0, 13'h0001, 13'h0001, 13'h0002);
      run_case(1'b1, 3'h1, 1'b0, 13'h0, 13'h1ff7, 13'h000f);
      run_case(1'b1, 3'h2, 1'b0, 13'h0, 13'h1f7f, 13'h00ff);
      run_case(1'b1, 3'h3, 1'b0, 13'h0, 13'h18ff, 13'h0400);
      run_case(1'b1, 3'h3, 1'b1, 13'h0, 13'h0100, 13'h0000);
      run_case(1'b1, 3'h4, 1'b0, 13'h0, 13'h1aff, 13'h0700);
      run_case(1'b1, 3'h5, 1'b0, 13'h0, 13'h00ff, 13'h1000);
      run_case(1'b1, 3'h6, 1'b0, 13'h0, 13'h0f00, 13'h1f00);
      run_case(1'b1, 3'h7, 1'b0, 13'h0, 13'h1f03, 13'h0707);
      run_case(1'b1, 3'h4, 1'b0, 13'h0100, 13'h0400, 13'h0600);
      test_delay();
      test_no_wake();
      report_and_stop();
   end

   initial begin
      #100000;
      errors++;
      report_and_stop();
   end
endmodule
